// ### design/flash_guard_cfg.svh
// constants for the flash erase and protection controller
`ifndef FLASH_GUARD_CFG_SVH
`define FLASH_GUARD_CFG_SVH
`define FG_ADDR_W      13
`define FG_UNIT_W      10
`define FG_REGION_W    11
`define FG_NUM_UNITS   8
`define FG_NUM_REGIONS 4
`define FG_WORD_W      8
`define FG_ERASED_BYTE 8'hff
`define FG_NO_DATA     8'h00
`endif

// ### design/flash_guard_pkg.sv
// types for the flash erase and protection controller
package flash_guard_pkg;
   typedef enum logic [1:0] {
      req_fetch,
      req_data,
      req_debug
   } read_src_e;

   typedef enum logic [1:0] {
      prot_none,
      prot_read_only,
      prot_exec_only
   } prot_mode_e;

   typedef enum logic [1:0] {
      st_idle,
      st_read,
      st_program,
      st_erase
   } ctl_state_e;
endpackage

// ### design/flash_region_check.sv
// per-region protection check
`include "flash_guard_cfg.svh"
module flash_region_check
   import flash_guard_pkg::*;
(
   input  wire logic [1:0] mode_in,
   input  wire logic       hit_in,
   input  wire logic       is_write_in,
   input  wire logic       is_fetch_in,
   output logic            deny_out
);
   always_comb begin
      deny_out = 1'b0;
      if (hit_in) begin
         if (mode_in == 2'(prot_read_only) && is_write_in) begin
            deny_out = 1'b1;
         end
         else if (mode_in == 2'(prot_exec_only) && is_write_in) begin
            deny_out = 1'b1;
         end
         else if (mode_in == 2'(prot_exec_only) && !is_fetch_in) begin
            deny_out = 1'b1;
         end
      end
   end
endmodule

// ### design/flash_guard.sv
// flash erase and protection controller with flip-flop array
`include "flash_guard_cfg.svh"

// Notes on behaviour
// - array holds eight kilobytes; all decisions use that address range
// - erase works on one-kilobyte units, leaving other units untouched
// - an erased unit reads back all ones
// - protection set per two-kilobyte region: read-only or execute-only
// - read-only region refuses every erase and program
// - execute-only region refuses every erase and program
// - execute-only region gives data only to instruction fetches
module flash_guard
   import flash_guard_pkg::*;
#(
   parameter int ADDR_W  = `FG_ADDR_W,
   parameter int WORD_W  = `FG_WORD_W,
   parameter int REGIONS = `FG_NUM_REGIONS
)(
   input  wire logic                 ref_clk_in,
   input  wire logic                 reset_in,
   input  wire logic                 rd_req_in,
   input  wire logic [1:0]           rd_src_in,
   input  wire logic                 prog_req_in,
   input  wire logic                 erase_req_in,
   input  wire logic [ADDR_W-1:0]    addr_in,
   input  wire logic [WORD_W-1:0]    wdata_in,
   input  wire logic [2*REGIONS-1:0] prot_in,
   output logic [WORD_W-1:0]         rdata_out,
   output logic                      done_out,
   output logic                      violation_out
);
   // ***********************************************
   // state
   // ***********************************************
   localparam int DEPTH = 1 << ADDR_W;
   localparam int UNIT_WORDS = 1 << `FG_UNIT_W;

   logic [WORD_W-1:0] mem_r [DEPTH];
   logic [WORD_W-1:0] rdata_r, rdata_nxt;
   logic              done_r, done_nxt, viol_r, viol_nxt;
   ctl_state_e        state_r, state_nxt;
   logic [ADDR_W-1:0] ptr_r, ptr_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [WORD_W-1:0] wdat_r, wdat_nxt;
   logic [REGIONS-1:0] deny_vec;
   logic              deny;
   logic              wr_req;
   logic              mem_we;
   logic [ADDR_W-1:0] mem_wa;
   logic [WORD_W-1:0] mem_wd;
   logic [`FG_UNIT_W:0] erase_cyc_r, erase_cyc_nxt;

   assign wr_req = prog_req_in | erase_req_in;

   // ***********************************************
   // protection check
   // ***********************************************
   // one checker per region
   for (genvar g = 0; g < REGIONS; g++) begin : g_reg
      flash_region_check u_chk (
         .mode_in     (prot_in[2*g +: 2]),
         .hit_in      (addr_in[ADDR_W-1:`FG_REGION_W] == (ADDR_W-`FG_REGION_W)'(g)),
         .is_write_in (wr_req),
         .is_fetch_in (rd_src_in == 2'(req_fetch)),
         .deny_out    (deny_vec[g])
      );
   end
   assign deny = |deny_vec;

   // ***********************************************
   // control
   // ***********************************************
   always_comb begin
      state_nxt = state_r;
      ptr_nxt   = ptr_r;
      addr_nxt  = addr_r;
      wdat_nxt  = wdat_r;
      rdata_nxt = rdata_r;
      done_nxt  = 1'b0;
      viol_nxt  = 1'b0;
      mem_we    = 1'b0;
      mem_wa    = ptr_r;
      mem_wd    = `FG_ERASED_BYTE;
      case (state_r)
         st_idle: begin
            if (rd_req_in || wr_req) begin
               // refused access, no data, no change
               if (deny) begin
                  viol_nxt  = 1'b1;
                  done_nxt  = 1'b1;
                  rdata_nxt = `FG_NO_DATA;
               end else if (erase_req_in) begin
                  ptr_nxt   = {addr_in[ADDR_W-1:`FG_UNIT_W], {`FG_UNIT_W{1'b0}}};
                  state_nxt = st_erase;
               end else if (prog_req_in) begin
                  addr_nxt  = addr_in;
                  wdat_nxt  = wdata_in;
                  state_nxt = st_program;
               end else begin
                  addr_nxt  = addr_in;
                  state_nxt = st_read;
               end
            end
         end
         st_read: begin
            rdata_nxt = mem_r[addr_r];
            done_nxt  = 1'b1;
            state_nxt = st_idle;
         end
         st_program: begin
            // flash programming only clears bits
            mem_we    = 1'b1;
            mem_wa    = addr_r;
            mem_wd    = mem_r[addr_r] & wdat_r;
            done_nxt  = 1'b1;
            state_nxt = st_idle;
         end
         st_erase: begin
            mem_we  = 1'b1;
            mem_wa  = ptr_r;
            mem_wd  = `FG_ERASED_BYTE;
            ptr_nxt = ptr_r + 1'b1;
            if (ptr_r[`FG_UNIT_W-1:0] == {`FG_UNIT_W{1'b1}}) begin
               done_nxt  = 1'b1;
               state_nxt = st_idle;
            end
         end
         default: state_nxt = st_idle;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_r <= st_idle;
         ptr_r   <= '0;
         addr_r  <= '0;
         wdat_r  <= '0;
         rdata_r <= '0;
         done_r  <= 1'b0;
         viol_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ptr_r   <= ptr_nxt;
         addr_r  <= addr_nxt;
         wdat_r  <= wdat_nxt;
         rdata_r <= rdata_nxt;
         done_r  <= done_nxt;
         viol_r  <= viol_nxt;
      end
   end

   // array not reset: contents survive reset like real flash
   always_ff @(posedge ref_clk_in) begin
      if (mem_we) begin
         mem_r[mem_wa] <= mem_wd;
      end
   end

   assign rdata_out     = rdata_r;
   assign done_out      = done_r;
   assign violation_out = viol_r;

   // ***********************************************
   // checks
   // ***********************************************
   // unit erase length
   // counter instead of a long delay range, which tools unroll slowly
   always_comb begin
      erase_cyc_nxt = '0;
      if (state_r == st_erase) begin
         erase_cyc_nxt = erase_cyc_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         erase_cyc_r <= '0;
      end else begin
         erase_cyc_r <= erase_cyc_nxt;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   sequence s_denied_req;
      state_r == st_idle && (rd_req_in || wr_req) && deny;
   endsequence

   sequence s_flag_and_blank;
      viol_r && done_r && rdata_r == `FG_NO_DATA;
   endsequence

   a_denied_flagged: assert property (s_denied_req |=> s_flag_and_blank)
      else $error("refused access not flagged");

   a_denied_no_write: assert property (s_denied_req |=> state_r == st_idle ##1 !mem_we)
      else $error("refused access changed array");

   a_ro_no_write: assert property (state_r == st_idle && wr_req
         && prot_in[2*addr_in[ADDR_W-1:`FG_REGION_W] +: 2] == 2'(prot_read_only)
         |=> viol_r)
      else $error("write into read-only region accepted");

   a_xo_no_write: assert property (state_r == st_idle && wr_req
         && prot_in[2*addr_in[ADDR_W-1:`FG_REGION_W] +: 2] == 2'(prot_exec_only)
         |=> viol_r && state_r == st_idle)
      else $error("write into execute-only region accepted");

   a_xo_data_read: assert property (state_r == st_idle && rd_req_in && !wr_req
         && rd_src_in != 2'(req_fetch)
         && prot_in[2*addr_in[ADDR_W-1:`FG_REGION_W] +: 2] == 2'(prot_exec_only)
         |=> viol_r && rdata_r == `FG_NO_DATA)
      else $error("execute-only data leaked");

   a_xo_fetch_ok: assert property (state_r == st_idle && rd_req_in && !wr_req
         && rd_src_in == 2'(req_fetch) |=> state_r == st_read ##1 done_r && !viol_r)
      else $error("fetch refused");

   a_erase_ones: assert property (state_r == st_erase |-> mem_we
         && mem_wd == `FG_ERASED_BYTE)
      else $error("erase wrote non-ones");

   a_erase_unit: assert property (state_r == st_erase && state_nxt == st_erase
         |=> $stable(ptr_r[ADDR_W-1:`FG_UNIT_W]))
      else $error("erase left its unit");

   a_erase_len: assert property (state_r == st_erase
         |-> erase_cyc_r < (`FG_UNIT_W+1)'(UNIT_WORDS))
      else $error("erase ran past one unit");

   a_erase_ends: assert property (state_r == st_erase
         && erase_cyc_r == (`FG_UNIT_W+1)'(UNIT_WORDS-1)
         |=> state_r == st_idle && done_r)
      else $error("erase did not end after one unit");
endmodule

// ### verification/flash_requester_model.sv
// requester side model: fetch, data and debug accesses to the flash
module flash_requester_model (
   input  wire logic  clk_in,
   output logic       rd_req_out,
   output logic [1:0] rd_src_out,
   output logic       prog_req_out,
   output logic       erase_req_out,
   output logic [12:0] addr_out,
   output logic [7:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {rd_req_out, rd_src_out, prog_req_out, erase_req_out} = '0;
      addr_out = '0;
      wdata_out = '0;
   end
   // one-cycle request; on release request lines clear, address and data invert so stale values never match
   task automatic issue(input int kind, input logic [1:0] src, input logic [12:0] a,
                        input logic [7:0] d);
      @(negedge clk_in);
      rd_req_out = (kind == 0);
      prog_req_out = (kind == 1);
      erase_req_out = (kind == 2);
      rd_src_out = src;
      addr_out = a;
      wdata_out = d;
      @(negedge clk_in);
      {rd_req_out, prog_req_out, erase_req_out} = '0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
endmodule

// ### verification/flash_guard_bench.sv
// self-checking bench for the flash erase and protection controller
module flash_guard_bench import flash_guard_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        rd_req, prog_req, erase_req, done, violation;
   logic [1:0]  rd_src;
   logic [12:0] addr, a;
   logic [7:0]  wdata, rdata, r, last = 8'h00, lfsr = 8'h26;
   logic [7:0]  prot = 8'h00;
   logic [7:0]  mem [8192];
   logic [8:0]  expq [$];
   int          errors, n_compared, u, g, m, s;
   always #25 ref_clk_in = ~ref_clk_in;
   flash_requester_model flash_requester_model_i (.clk_in(ref_clk_in),
      .rd_req_out(rd_req), .rd_src_out(rd_src), .prog_req_out(prog_req),
      .erase_req_out(erase_req), .addr_out(addr), .wdata_out(wdata));
   flash_guard flash_guard_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .rd_req_in(rd_req), .rd_src_in(rd_src), .prog_req_in(prog_req),
      .erase_req_in(erase_req), .addr_in(addr), .wdata_in(wdata), .prot_in(prot),
      .rdata_out(rdata), .done_out(done), .violation_out(violation));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   task automatic conclude();
      if (errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: result %h expected %h", $time, seen, exp);
      end
   endtask
   // kind 0 read, 1 program, 2 erase
   task automatic op(input int kind, input logic [1:0] src, input logic [12:0] ad,
                     input logic [7:0] d);
      logic [1:0] pm;
      logic       deny;
      int         i;
      pm = prot[2*ad[12:11] +: 2];
      deny = (kind != 0 && (pm == 2'h1 || pm == 2'h2)) || (kind == 0 && pm == 2'h2 && src != 2'h0);
      if (deny) last = 8'h00;
      else if (kind == 0) last = mem[ad];
      else if (kind == 1) mem[ad] = mem[ad] & d;
      else for (i = 0; i < 1024; i++) mem[{ad[12:10], i[9:0]}] = 8'hff;
      expq.push_back({deny, last});
      flash_requester_model_i.issue(kind, src, ad, d);
      for (i = 0; i < 1100 && done !== 1'b1; i++) @(negedge ref_clk_in);
      if (i == 1100) begin
         errors++;
         conclude();
      end
   endtask
   // ******************************
   // result watcher
   // ******************************
   always @(negedge ref_clk_in) begin
      if (done === 1'b1) begin
         check({violation, rdata}, expq.pop_front());
      end
   end
   initial begin
      repeat (2) @(negedge ref_clk_in);
      reset_in = 1'b0;
      for (u = 0; u < 8; u++) op(2, 2'h0, {u[2:0], 10'h000}, 8'h00);
      for (u = 0; u < 6; u++) begin
         r = rnd();
         a = {r[4:0], rnd()};
         op(0, 2'h0, a, 8'h00);
         op(1, 2'h0, a, rnd());
         op(0, 2'h1, a, 8'h00);
         op(1, 2'h0, a, rnd());
         op(0, 2'h2, a, 8'h00);
      end
      op(1, 2'h0, a ^ 13'h0400, 8'h5a);
      op(2, 2'h0, a, 8'h00);
      op(0, 2'h1, a ^ 13'h0400, 8'h00);
      op(0, 2'h1, a, 8'h00);
      for (m = 1; m < 4; m++) begin
         for (g = 0; g < 4; g++) begin
            prot = 8'h00;
            prot[2*g +: 2] = m[1:0];
            a = {g[1:0], 3'h0, rnd()};
            for (s = 0; s < 3; s++) op(0, s[1:0], a, 8'h00);
            op(1, 2'h0, a, 8'h00);
            op(2, 2'h0, a, 8'h00);
            op(0, 2'h0, a, 8'h00);
            op(1, 2'h0, a ^ 13'h0800, 8'h0f);
            op(0, 2'h1, a ^ 13'h0800, 8'h00);
         end
      end
      // let the watcher take the last result before the verdict
      @(negedge ref_clk_in);
      conclude();
   end
endmodule
